// ==== verilog/asw_regs.svh ====
// Constants for the sample output and serial write block
`ifndef ASW_REGS_SVH
`define ASW_REGS_SVH

// Conversion word and pin serializer
`define ASW_SAMPLE_BITS   16
`define ASW_PAIR_COUNT    4'h8
`define ASW_PAIR_LAST     4'h7
`define ASW_PIPE_LATENCY  5'h04
`define ASW_FIFO_DEPTH    16

// Serial write frame layout
`define ASW_FRAME_EDGES   5'h10
`define ASW_ADDR_MSB      10
`define ASW_ADDR_LSB      8
`define ASW_DATA_MSB      7
`define ASW_DATA_LSB      0

// Register file
`define ASW_NUM_REGS      3'h6
`define ASW_RESET_BIT     7
`define ASW_POWER_BIT     0
`define ASW_CLKMODE_BIT   1
`define ASW_CDS_BIT       4
`define ASW_INIT_SETUP    8'h00
`define ASW_INIT_OFFSET   8'h80
`define ASW_INIT_OTHER    8'h00

`endif

// ==== verilog/asw_pkg.sv ====
// Types shared by the sample output and serial write block
`default_nettype none
package asw_pkg;
   typedef enum logic [0:0] {
      ASW_SER_IDLE  = 1'b0,
      ASW_SER_SHIFT = 1'b1
   } asw_ser_state_t;

   typedef logic [7:0] asw_byte_t;
endpackage
`default_nettype wire

// ==== verilog/asw_fifo.sv ====
// Sample FIFO with registered head word
`timescale 1ns/100ps
`default_nettype none
module asw_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("asw_fifo depth must be a power of two of at least two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [WIDTH-1:0] head_reg;
   logic             head_valid_reg;

   wire              push        = in_valid_in && in_ready_out;
   wire              pop         = out_ready_in && out_valid_out;
   wire [AW-1:0]     rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
   wire [AW:0]       count_next  = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   // A word written into the slot being read lands one cycle late in the head
   wire              head_hazard = push && (wr_ptr_reg == rd_ptr_next);

   assign in_ready_out  = (count_reg != DEPTH[AW:0]);
   assign out_valid_out = head_valid_reg;
   assign out_data_out  = head_reg;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_in;
      end
      head_reg <= mem[rd_ptr_next];
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr_reg     <= '0;
         rd_ptr_reg     <= '0;
         count_reg      <= '0;
         head_valid_reg <= 1'b0;
      end else begin
         wr_ptr_reg     <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
         rd_ptr_reg     <= rd_ptr_next;
         count_reg      <= count_next;
         head_valid_reg <= (count_next != '0) && !head_hazard;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/asw_core.sv ====
// Sample output serializer and shared-pin serial register write
// Operation
// R1 - Host repeats sample pulse every 8/4 clocks
// R2 - Sample appears after four pulse periods
// R3 - Enable low releases pins as serial inputs
// R4 - Serial bit taken on shift clock rise
// R5 - Frame: five zeros, address, data, MSB first
// R6 - Host gives at least sixteen clock rises
// R7 - Only last sixteen captured bits count
// R8 - Pins change on clock rising edges
// R9 - Reset bit zero holds other registers
// R10 - Commit frame and resume at enable rise
// R11 - Decode address, drop unimplemented locations
`timescale 1ns/100ps
`default_nettype none
`include "asw_regs.svh"
module asw_core
   import asw_pkg::*;
#(
   parameter int FIFO_DEPTH = `ASW_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        hard_reset_n_in,
   // Sampling pulse and converter result
   input  wire logic        pixel_sample_pulse_in,
   input  wire logic [15:0] conv_data_in,
   output logic             conv_ready_out,
   // Shared result / serial pins
   input  wire logic        serial_write_enable_n_in,
   input  wire logic        result_pin_lo_in,
   output logic             result_pin_lo_out,
   output logic             result_pin_lo_oe_out,
   input  wire logic        result_pin_hi_in,
   output logic             result_pin_hi_out,
   output logic             result_pin_hi_oe_out,
   // Register contents
   output logic [7:0]       setup_word_out,
   output logic [7:0]       offset_word_out,
   output logic [7:0]       gain_word_out,
   output logic [7:0]       shd_word_out,
   output logic [7:0]       test_a_word_out,
   output logic [7:0]       test_b_word_out,
   output logic             correlated_double_sampling_mode_out
);
   if (FIFO_DEPTH < `ASW_PIPE_LATENCY + 1) begin : g_bad_depth
      $error("asw_core FIFO depth must exceed the pipeline latency");
   end

   // Pin synchronisers: stage 1 is read only by stage 2
   logic [1:0] pulse_sync_reg;
   logic [1:0] en_sync_reg;
   logic [1:0] sclk_sync_reg;
   logic [1:0] sdat_sync_reg;
   logic [1:0] hrst_sync_reg;
   logic       pulse_last_reg;
   logic       sclk_last_reg;
   logic       en_last_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pulse_sync_reg <= 2'h0;
         en_sync_reg    <= 2'h3;
         sclk_sync_reg  <= 2'h0;
         sdat_sync_reg  <= 2'h0;
         hrst_sync_reg  <= 2'h3;
         pulse_last_reg <= 1'b0;
         sclk_last_reg  <= 1'b0;
         en_last_reg    <= 1'b1;
      end else begin
         pulse_sync_reg <= {pulse_sync_reg[0], pixel_sample_pulse_in};
         en_sync_reg    <= {en_sync_reg[0], serial_write_enable_n_in};
         sclk_sync_reg  <= {sclk_sync_reg[0], result_pin_lo_in};
         sdat_sync_reg  <= {sdat_sync_reg[0], result_pin_hi_in};
         hrst_sync_reg  <= {hrst_sync_reg[0], hard_reset_n_in};
         pulse_last_reg <= pulse_sync_reg[1];
         sclk_last_reg  <= sclk_sync_reg[1];
         en_last_reg    <= en_sync_reg[1];
      end
   end

   wire en_n_s     = en_sync_reg[1];
   wire sdat_s     = sdat_sync_reg[1];
   wire pulse_rise = pulse_sync_reg[1] && !pulse_last_reg;
   wire sclk_rise  = sclk_sync_reg[1] && !sclk_last_reg && !en_n_s;  // [R4]
   wire commit_ev  = en_n_s && !en_last_reg;                          // [R10]
   wire reg_rst    = rst_in || !hrst_sync_reg[1];

   // Serial frame capture
   logic [15:0] frame_reg;
   logic [4:0]  edge_cnt_reg;
   logic [2:0]  frame_addr;
   asw_byte_t   frame_data;

   assign frame_addr = frame_reg[`ASW_ADDR_MSB:`ASW_ADDR_LSB];
   assign frame_data = frame_reg[`ASW_DATA_MSB:`ASW_DATA_LSB];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         frame_reg    <= 16'h0000;
         edge_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
         // Older bits fall off the top, so the last sixteen edges win
         frame_reg    <= {frame_reg[14:0], sdat_s};                         // [R4] [R7]
         edge_cnt_reg <= (edge_cnt_reg == `ASW_FRAME_EDGES) ? edge_cnt_reg
                                                             : edge_cnt_reg + 5'h01;
      end else if (en_n_s) begin
         edge_cnt_reg <= 5'h00;
      end
   end

   // A short frame has no defined content, so it is dropped
   wire frame_ok = commit_ev && (edge_cnt_reg == `ASW_FRAME_EDGES);   // [R10]
   wire addr_ok  = frame_addr < `ASW_NUM_REGS;                         // [R11]
   wire do_write = frame_ok && addr_ok;

   // Register file
   asw_byte_t regs_reg [6];
   wire       released = regs_reg[0][`ASW_RESET_BIT];

   function automatic asw_byte_t reg_init(input int idx);
      reg_init = (idx == 0) ? `ASW_INIT_SETUP : (idx == 1) ? `ASW_INIT_OFFSET : `ASW_INIT_OTHER;
   endfunction

   always_ff @(posedge clk_in) begin
      if (reg_rst) begin
         for (int i = 0; i < 6; i++) begin
            regs_reg[i] <= reg_init(i);
         end
      end else begin
         if (do_write && frame_addr == 3'h0) begin
            // Only the reset bit is writable while the bank is held
            regs_reg[0] <= released ? frame_data
                                    : {frame_data[`ASW_RESET_BIT], regs_reg[0][6:0]};  // [R9]
         end
         for (int i = 1; i < 6; i++) begin
            if (!released) begin
               regs_reg[i] <= reg_init(i);                                  // [R9]
            end else if (do_write && frame_addr == 3'(i)) begin
               regs_reg[i] <= frame_data;                                   // [R11]
            end
         end
      end
   end

   assign setup_word_out   = regs_reg[0];
   assign offset_word_out  = regs_reg[1];
   assign gain_word_out    = regs_reg[2];
   assign shd_word_out     = regs_reg[3];
   assign test_a_word_out  = regs_reg[4];
   assign test_b_word_out  = regs_reg[5];
   assign correlated_double_sampling_mode_out = regs_reg[0][`ASW_CDS_BIT];

   // Conversion pipeline: samples queue until four pulses later
   wire        running = regs_reg[0][`ASW_POWER_BIT];
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [15:0] fifo_out_data;
   logic [4:0] pend_reg;
   wire        push = pulse_rise && running && fifo_in_ready;
   // Serializer stalls while the pins are lent to the serial port
   wire        pop  = pulse_rise && running && en_n_s && fifo_out_valid
                      && (pend_reg == `ASW_PIPE_LATENCY);                   // [R2]

   // Registered, so it lags the buffer fill by one cycle
   logic       conv_ready_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         conv_ready_reg <= 1'b0;
      end else begin
         conv_ready_reg <= fifo_in_ready;
      end
   end

   assign conv_ready_out = conv_ready_reg;

   asw_fifo #(
      .WIDTH (`ASW_SAMPLE_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      // Power-down empties the buffer together with the pending count
      .rst_in        (rst_in || !running),
      .in_valid_in   (pulse_rise && running),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (conv_data_in),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (pop),
      .out_data_out  (fifo_out_data)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in || !running) begin
         pend_reg <= 5'h00;
      end else begin
         pend_reg <= pend_reg + {4'h0, push} - {4'h0, pop};
      end
   end

   // Pair serializer, one pair per rising clock edge
   asw_ser_state_t state_reg;
   logic [15:0]    word_reg;
   logic [3:0]     pair_reg;
   logic           lo_reg;
   logic           hi_reg;
   logic           oe_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_reg <= ASW_SER_IDLE;
         word_reg  <= 16'h0000;
         pair_reg  <= 4'h0;
         lo_reg    <= 1'b0;
         hi_reg    <= 1'b0;
         oe_reg    <= 1'b0;
      end else begin
         oe_reg <= en_n_s;                                                  // [R3] [R10]
         // The last pair leaves on the same edge that may load the next word
         if (state_reg == ASW_SER_SHIFT) begin
            hi_reg <= word_reg[15];                                         // [R8]
            lo_reg <= word_reg[14];
         end
         if (pop) begin
            state_reg <= ASW_SER_SHIFT;
            word_reg  <= fifo_out_data;
            pair_reg  <= 4'h0;
         end else begin
            case (state_reg)
               ASW_SER_IDLE: begin
                  pair_reg <= 4'h0;
               end
               ASW_SER_SHIFT: begin
                  word_reg <= {word_reg[13:0], 2'h0};
                  pair_reg <= pair_reg + 4'h1;
                  if (pair_reg == `ASW_PAIR_LAST || !en_n_s) begin
                     state_reg <= ASW_SER_IDLE;
                  end
               end
               default: begin
                  state_reg <= ASW_SER_IDLE;
               end
            endcase
         end
      end
   end

   assign result_pin_lo_out    = lo_reg;
   assign result_pin_hi_out    = hi_reg;
   assign result_pin_lo_oe_out = oe_reg;
   assign result_pin_hi_oe_out = oe_reg;

   // Checks
   chk_pins_release: assert property (@(posedge clk_in) disable iff (rst_in)  // [R3]
      !en_n_s |=> !result_pin_lo_oe_out && !result_pin_hi_oe_out)
      else $error("pins still driven during serial write");

   chk_pins_resume: assert property (@(posedge clk_in) disable iff (rst_in)  // [R10]
      commit_ev |=> result_pin_lo_oe_out && result_pin_hi_oe_out)
      else $error("pins not driven again after serial write");

   chk_pipe_latency: assert property (@(posedge clk_in) disable iff (rst_in)  // [R2]
      pulse_rise && running && en_n_s && pend_reg == `ASW_PIPE_LATENCY |-> pop)
      else $error("sample left the pipeline at wrong depth");

   chk_bit_capture: assert property (@(posedge clk_in) disable iff (rst_in)  // [R4]
      sclk_rise |=> frame_reg[0] == $past(sdat_s) && frame_reg[15:1] == $past(frame_reg[14:0]))
      else $error("serial bit not captured on clock rise");

   chk_last_sixteen: assert property (@(posedge clk_in) disable iff (rst_in)  // [R7]
      edge_cnt_reg <= `ASW_FRAME_EDGES)
      else $error("edge count passed frame length");

   chk_pair_order: assert property (@(posedge clk_in) disable iff (rst_in)  // [R8]
      pop ##1 (state_reg == ASW_SER_SHIFT && !pop)
      |=> result_pin_hi_out == $past(word_reg[15]) && result_pin_lo_out == $past(word_reg[14]))
      else $error("pair sent out of order");

   chk_reset_hold: assert property (@(posedge clk_in) disable iff (reg_rst)  // [R9]
      !released |=> regs_reg[1] == `ASW_INIT_OFFSET && regs_reg[2] == `ASW_INIT_OTHER)
      else $error("register changed while bank held in reset");

   chk_commit_write: assert property (@(posedge clk_in) disable iff (reg_rst)  // [R11]
      do_write && frame_addr == 3'h1 && released |=> offset_word_out == $past(frame_data))
      else $error("addressed register not written");

   chk_bad_addr: assert property (@(posedge clk_in) disable iff (reg_rst)  // [R11]
      frame_ok && !addr_ok && released |=> $stable(offset_word_out) && $stable(gain_word_out))
      else $error("write to unimplemented location landed");
endmodule
`default_nettype wire

// ==== test/asw_host_model.sv ====
// Host controller model: sample pulses and serial register writes
`timescale 1ns/100ps
`default_nettype none
module asw_host_model (
   // Clock
   input  wire logic clk_in,
   // Host pins
   output logic      pixel_sample_pulse_out,
   output logic      serial_write_enable_n_out,
   output logic      serial_shift_clock_out,
   output logic      serial_shift_data_out,
   output logic      shift_drive_out
);
   initial begin
      pixel_sample_pulse_out = 1'b0;
      serial_write_enable_n_out = 1'b1;
      serial_shift_clock_out = 1'b0;
      serial_shift_data_out = 1'b0;
      shift_drive_out = 1'b0;
   end

   // High for w rising edges, one pixel every 8 clocks
   task automatic pulse(input int w);
      pixel_sample_pulse_out <= 1'b1;
      repeat (w) @(posedge clk_in);
      pixel_sample_pulse_out <= 1'b0;
      repeat (8 - w) @(posedge clk_in);
   endtask

   task automatic hold_enable(input logic v);
      serial_write_enable_n_out <= v;
   endtask

   // Sends bits nbits-1..0; 200 ns shift clock, low outside frames
   task automatic frame(input int nbits, input logic [31:0] bits);
      serial_write_enable_n_out <= 1'b0;
      shift_drive_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      for (int i = nbits - 1; i >= 0; i--) begin
         // Data settles 100 ns before the rise and holds 100 ns after
         serial_shift_data_out <= bits[i];
         repeat (4) @(posedge clk_in);
         serial_shift_clock_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         serial_shift_clock_out <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
      serial_write_enable_n_out <= 1'b1;
      shift_drive_out <= 1'b0;
      repeat (8) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// ==== test/asw_core_bench.sv ====
// Self-checking bench for the sample output and serial write block
`timescale 1ns/100ps
`default_nettype none
module asw_core_bench;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [15:0] conv_data = 16'h0000;
   wire logic   pulse, en_n, sclk, serial_shift_data, drive, pin_lo, pin_hi;
   logic        conv_ready, lo_out, lo_oe, hi_out, hi_oe, correlated_double_sampling_mode;
   logic [7:0]  words [0:5];
   logic [31:0] seed = 32'h0C190DBF;
   logic [15:0] word;
   logic [15:0] sent_q[$];
   logic [15:0] due_q[$];
   int          launch_q[$];
   int          regs [0:5] = '{0, 128, 0, 0, 0, 0};
   int          mismatches = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          pairs = 0;

   always #12.5 clk_in = ~clk_in;
   // Released pins fall to the pull-down level
   assign pin_lo = lo_oe ? lo_out : (drive ? sclk : 1'b0);
   assign pin_hi = hi_oe ? hi_out : (drive ? serial_shift_data : 1'b0);

   asw_host_model u_asw_host_model (.clk_in(clk_in), .pixel_sample_pulse_out(pulse),
      .serial_write_enable_n_out(en_n), .serial_shift_clock_out(sclk),
      .serial_shift_data_out(serial_shift_data), .shift_drive_out(drive));

   asw_core u_asw_core (.clk_in(clk_in), .rst_in(rst_in), .hard_reset_n_in(1'b1),
      .pixel_sample_pulse_in(pulse), .conv_data_in(conv_data), .conv_ready_out(conv_ready),
      .serial_write_enable_n_in(en_n), .result_pin_lo_in(pin_lo), .result_pin_lo_out(lo_out),
      .result_pin_lo_oe_out(lo_oe), .result_pin_hi_in(pin_hi), .result_pin_hi_out(hi_out),
      .result_pin_hi_oe_out(hi_oe), .setup_word_out(words[0]), .offset_word_out(words[1]),
      .gain_word_out(words[2]), .shd_word_out(words[3]), .test_a_word_out(words[4]),
      .test_b_word_out(words[5]), .correlated_double_sampling_mode_out(correlated_double_sampling_mode));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_regs();
      for (int a = 0; a < 6; a++) chk("register word", regs[a], words[a]);
      chk("cds mode", regs[0][4], correlated_double_sampling_mode);
   endtask

   // Frame of n shift edges; the upper bits ahead of the 16-bit frame are noise
   task automatic write(input int n, input logic [2:0] addr, input logic [7:0] data);
      seed = lfsr(seed);
      fork
         u_asw_host_model.frame(n, {seed[31:16], 5'h00, addr, data});
         begin
            repeat (40) @(posedge clk_in);
            chk("pins released", 2'h0, {lo_oe, hi_oe});
         end
      join
      chk("pins driven again", 2'h3, {lo_oe, hi_oe});
      if (n >= 16 && addr < 3'h6) begin
         if (regs[0] < 128) begin
            if (addr == 3'h0) regs[0] = (regs[0] & 8'h7F) | (data & 8'h80);
         end else begin
            regs[addr] = data;
         end
         // A held bank returns to its initial values
         if (regs[0] < 128) for (int a = 1; a < 6; a++) regs[a] = (a == 1) ? 128 : 0;
      end
      check_regs();
   endtask

   // Word sent at pulse k is due on the pins from edge +5 of pulse k+4
   task automatic stream(input int count);
      int w;
      for (int k = 0; k < count; k++) begin
         seed = lfsr(seed);
         w = 1 + int'(seed[7:0]) % 3;
         conv_data <= seed[31:16];
         sent_q.push_back(seed[31:16]);
         if (sent_q.size() > 4) begin
            due_q.push_back(sent_q.pop_front());
            launch_q.push_back(cyc + 5);
         end
         u_asw_host_model.pulse(w);
      end
      repeat (16) @(posedge clk_in);
      chk("fifo ready", 1'b1, conv_ready);
   endtask

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (pairs > 0 || (launch_q.size() > 0 && cyc == launch_q[0])) begin
         if (pairs == 0) void'(launch_q.pop_front());
         word = {word[13:0], pin_hi, pin_lo};
         pairs = pairs + 1;
         if (pairs == 8) begin
            chk("sample word", due_q.pop_front(), word);
            pairs = 0;
         end
      end
   end

   always @(posedge clk_in) begin
      if (cyc == 8000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      check_regs();
      write(16, 3'h1, 8'h55);
      write(16, 3'h0, 8'h81);
      write(16, 3'h0, 8'h81);
      for (int a = 1; a < 6; a++) begin
         seed = lfsr(seed);
         write(16, a[2:0], seed[7:0]);
      end
      write(16, 3'h6, 8'hAA);
      write(16, 3'h7, 8'h55);
      write(15, 3'h2, 8'h3C);
      write(20, 3'h3, 8'hC3);
      write(16, 3'h0, 8'h01);
      write(16, 3'h0, 8'h81);
      for (int a = 1; a < 6; a++) write(16, a[2:0], 8'h5A + a[7:0]);
      stream(24);
      write(16, 3'h0, 8'h91);
      stream(24);
      // Pops refused while enabled for writes, so the buffer fills
      u_asw_host_model.hold_enable(1'b0);
      repeat (20) u_asw_host_model.pulse(2);
      chk("fifo full", 1'b0, conv_ready);
      stop_test();
   end
endmodule
`default_nettype wire
